/* File: verilog/display_arbiter.sv */
// Display memory arbiter between a 16-bit host and a video display generator.
// Behaviour
// R01: Host display access switches memory to host.
// R02: Float video address, deselect decoder, then buffers.
// R03: Host buffers high impedance when not accessing.
// R04: Otherwise video decoder selected, generator scans.
// R05: Display memory data path twelve bits.
// R06: Four-bit latch feeds generator mode pins.
// R07: Latch loads only on even-address writes.
// R08: Latch output constant between host writes.
// R09: Frame sync low outside active window.
// R10: Host should write during inactive frame period.
// R11: Device acknowledges; host waits for acknowledge.
// R12: Tap zero no waits, each tap two more. Code: tap one adds one edge, taps two and three two each.
// R13: Tap chosen covers memory access time.
// R14: Tap chosen covers memory data setup time.
// R15: 300 ns memory uses tap one.
// R16: Generator mode set by eight control pins.
// R17: Wait register clears between host accesses.
// R18: Reset grants memory to video, ack negated.
`timescale 1ns/1ps
module display_arbiter
  import arbiter_pkg::*;
#(
  parameter logic [HOST_ADDR_W-1:0] DISP_BASE = DISP_BASE_DEFAULT,
  parameter logic [1:0] WAIT_TAP = TAP_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire host_req_t host_req,
  input wire logic [DISP_DATA_W-1:0] mem_rdata,
  input wire logic [MODE_PINS-MODE_W-1:0] static_mode_bits,
  input wire logic frame_sync_pin,
  output logic [HOST_DATA_W-1:0] host_rdata,
  output logic host_rdata_oe,
  output logic transfer_acknowledge_n,
  output logic [DISP_ADDR_W-1:0] mem_addr,
  output logic [DISP_DATA_W-1:0] mem_wdata,
  output logic mem_wdata_oe,
  output logic mem_we_n,
  output mem_ctl_t mem_ctl,
  output logic [MODE_PINS-1:0] video_display_generator_mode,
  output logic frame_inactive
);

  // Tap must cover both memory figures for the fitted memory.
  // R13 access time covered
  // R14 setup time covered
  // R15 fitted memory tap one
  localparam bit TAP_FITS = (tap_access_ns(WAIT_TAP) >= MEM_ACCESS_NS)
    && (tap_setup_ns(WAIT_TAP) >= MEM_ACCESS_NS - (ACCESS_NS_TAP0 - SETUP_NS_TAP0));
  // Selected tap, forced up to the fitted tap if a slower choice is not made.
  localparam logic [1:0] TAP_USED = TAP_FITS ? WAIT_TAP : TAP_DEFAULT;
  // A tap that is too short is raised rather than refused, so a wrong parameter
  // costs speed but never corrupts a memory cycle.

  // Host request registered once, since address strobe comes from the processor bus.
  host_req_t req_q;
  // Ownership state of the memory bus.
  owner_t state_q;
  owner_t state_d;
  // Host address offset into the display region.
  logic [HOST_ADDR_W-1:0] offset;
  // Host is addressing the display region this cycle.
  logic disp_hit;
  // Wait shifter runs while the host owns the buffers in HOST_ON, until the acknowledge.
  logic wait_run;
  logic wait_ack;
  // Mode latch load strobe and value.
  logic mode_load;
  logic [MODE_W-1:0] mode_val;
  // Registered outputs' next values.
  mem_ctl_t ctl_d;
  // Acknowledge next value, active low.
  logic ack_n_d;
  logic rd_oe_d;
  logic wd_oe_d;
  logic we_n_d;
  logic [HOST_DATA_W-1:0] rdata_d;
  // Frame sync sampled through three flops.
  logic [2:0] fs_sync_q;
  // Frame sync level kept while the last two flops disagree.
  logic fs_q;
  logic fs_d;

  // Decode helper: is a host word address within the 6K display region.
  // The lower bound test stops a wrapped subtraction from looking like a hit.
  function automatic logic in_display(input logic [HOST_ADDR_W-1:0] a);
    logic [HOST_ADDR_W-1:0] off;
    off = a - DISP_BASE;
    in_display = (a >= DISP_BASE) && (off < HOST_ADDR_W'(DISP_WORDS));
  endfunction

  // Combinational decode of the registered request.
  always_comb
  begin
    offset = req_q.addr - DISP_BASE;
    // R01 region decode
    disp_hit = !req_q.as_n && in_display(req_q.addr);
  end

  // Ownership sequencing: video, float address, deselect decoder, host on.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      OWN_VIDEO:
      begin
        // Video keeps the bus until a region hit is seen.
        // R01 switch to host
        if (disp_hit)
        begin
          state_d = FLOAT_VADDR;
        end
      end
      FLOAT_VADDR:
      begin
        // A strobe lifted early aborts the hand-over and returns the bus.
        // R02 then deselect decoder
        state_d = disp_hit ? DESEL_VDEC : OWN_VIDEO;
      end
      DESEL_VDEC:
      begin
        // Same abort path as the step before.
        // R02 then enable buffers
        state_d = disp_hit ? HOST_ON : OWN_VIDEO;
      end
      HOST_ON:
      begin
        // Stay until acknowledged, then wait for strobe release.
        if (!disp_hit)
        begin
          state_d = OWN_VIDEO;
        end
        // Acknowledge seen: move on to HOST_DONE.
        else if (wait_ack)
        begin
          state_d = HOST_DONE;
        end
      end
      HOST_DONE:
      begin
        // Cycle ends when the host lifts its strobe.
        // The acknowledge stays low here; the host picks the end of the cycle.
        if (!disp_hit)
        begin
          state_d = OWN_VIDEO;
        end
      end
      default:
      begin
        // Illegal code falls back to the safe video owner.
        state_d = OWN_VIDEO;
      end
    endcase
  end

  // Control outputs decoded from the next state so they leave flip-flops.
  always_comb
  begin
    ctl_d = '0;
    // R04 video owns by default
    ctl_d.vdec_sel = 1'b1;
    unique case (state_d)
      FLOAT_VADDR:
      begin
        // First step: video address lines let go.
        ctl_d.vaddr_float = 1'b1;
      end
      DESEL_VDEC:
      begin
        // Second step: video-side decoder off.
        ctl_d.vaddr_float = 1'b1;
        ctl_d.vdec_sel = 1'b0;
      end
      HOST_ON, HOST_DONE:
      begin
        // Last step: host buffers on, direction from the request.
        ctl_d.vaddr_float = 1'b1;
        ctl_d.vdec_sel = 1'b0;
        ctl_d.host_buf_en = 1'b1;
        ctl_d.host_drive_mem = !req_q.rw;
      end
      default:
      begin
        // R03 host isolated
        ctl_d.host_buf_en = 1'b0;
      end
    endcase
  end

  // The wait count starts only once the host buffers are on the memory.
  // Counting from the buffer enable gives the memory the whole wait span.
  assign wait_run = (state_q == HOST_ON) && disp_hit;

  // Acknowledge generator.
  // R12 tap shift register
  wait_shifter u_wait
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(wait_run),
    .tap_sel(TAP_USED),
    .ack(wait_ack)
  );

  // Data path and acknowledge next values.
  always_comb
  begin
    // R11 ack every access
    ack_n_d = !((state_d == HOST_DONE) || ((state_d == HOST_ON) && wait_ack));
    // Read buffers face the host only on a read.
    rd_oe_d = ctl_d.host_buf_en && req_q.rw;
    // Write drivers follow the memory-side direction bit.
    wd_oe_d = ctl_d.host_drive_mem;
    // The write strobe ends on the edge that lowers the acknowledge.
    we_n_d = !(ctl_d.host_drive_mem && (state_d == HOST_ON));
    // R05 twelve-bit data path
    // The upper host bits read back as zero, since they are not stored.
    rdata_d = {{(HOST_DATA_W-DISP_DATA_W){1'b0}}, mem_rdata};
  end

  // Even-address write into the region loads the mode latch once per access.
  // Loading a step before the buffers keeps the latch away from the write strobe.
  // R07 even writes only
  assign mode_load = (state_q == DESEL_VDEC) && disp_hit && !req_q.rw && !offset[0];

  // R06 four-bit mode latch
  mode_latch u_mode
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(mode_load),
    .din(req_q.wdata[MODE_LSB +: MODE_W]),
    .mode(mode_val)
  );

  // Frame sync from the generator: act once the second and third flops agree.
  always_comb
  begin
    // A disagreement means the pin is still settling; keep the old level.
    fs_d = (fs_sync_q[1] == fs_sync_q[2]) ? fs_sync_q[2] : fs_q;
  end

  // Request and synchroniser registers.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Idle request: strobe high, read direction.
      req_q <= '{as_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0};
      fs_sync_q <= 3'h0;
      fs_q <= 1'b0;
    end
    else
    begin
      // The host bus runs on this clock, so one register is enough.
      req_q <= host_req;
      fs_sync_q <= {fs_sync_q[1:0], frame_sync_pin};
      fs_q <= fs_d;
    end
  end

  // State and output registers.
  // R18 reset to video owner
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Video owns the bus, host cut off, acknowledge negated.
      state_q <= OWN_VIDEO;
      mem_ctl <= '{vaddr_float: 1'b0, vdec_sel: 1'b1, host_buf_en: 1'b0,
        host_drive_mem: 1'b0};
      transfer_acknowledge_n <= 1'b1;
      host_rdata_oe <= 1'b0;
      mem_wdata_oe <= 1'b0;
      mem_we_n <= 1'b1;
      host_rdata <= '0;
      mem_addr <= '0;
      mem_wdata <= '0;
      video_display_generator_mode <= '0;
      frame_inactive <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      mem_ctl <= ctl_d;
      transfer_acknowledge_n <= ack_n_d;
      host_rdata_oe <= rd_oe_d;
      mem_wdata_oe <= wd_oe_d;
      mem_we_n <= we_n_d;
      host_rdata <= rdata_d;
      // Address and write data follow the registered request every cycle.
      mem_addr <= offset[DISP_ADDR_W-1:0];
      mem_wdata <= req_q.wdata[DISP_DATA_W-1:0];
      // R16 eight mode pins
      video_display_generator_mode <= {static_mode_bits, mode_val};
      // R09 frame sync low inactive
      frame_inactive <= !fs_q;
    end
  end

endmodule

/* File: verilog/arbiter_pkg.sv */
// Shared constants and carrier types for the display memory arbiter.
package arbiter_pkg;

  // Host address width in words (word address, byte lane bit dropped).
  localparam int unsigned HOST_ADDR_W = 23;
  // Display memory word address width; 6K words need 13 bits.
  localparam int unsigned DISP_ADDR_W = 13;
  // Number of words in the display region (6K).
  localparam logic [DISP_ADDR_W-1:0] DISP_WORDS = 13'h1800;
  // Default base of the display region, in host word addresses.
  localparam logic [HOST_ADDR_W-1:0] DISP_BASE_DEFAULT = 23'h020000;
  // Width of the display memory data path.
  localparam int unsigned DISP_DATA_W = 12;
  // Host data bus width.
  localparam int unsigned HOST_DATA_W = 16;
  // Width of the mode latch and its position on the host data bus.
  localparam int unsigned MODE_W = 4;
  localparam int unsigned MODE_LSB = 12;
  // Number of mode control pins on the video display generator.
  localparam int unsigned MODE_PINS = 8;
  // Reset value of the mode latch.
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  // Wait states added per tap step.
  localparam int unsigned WAITS_PER_TAP = 2;
  // Number of taps on the wait shift register.
  localparam int unsigned TAP_COUNT = 4;
  // Processor clock period in picoseconds (50 MHz).
  localparam int unsigned CLK_PERIOD_PS = 20000;
  // Supported access times per tap, in nanoseconds.
  localparam int unsigned ACCESS_NS_TAP0 = 250;
  localparam int unsigned ACCESS_NS_TAP1 = 375;
  localparam int unsigned ACCESS_NS_TAP2 = 500;
  localparam int unsigned ACCESS_NS_TAP3 = 625;
  // Supported data setup times per tap, in nanoseconds.
  localparam int unsigned SETUP_NS_TAP0 = 230;
  localparam int unsigned SETUP_NS_TAP1 = 355;
  localparam int unsigned SETUP_NS_TAP2 = 480;
  localparam int unsigned SETUP_NS_TAP3 = 605;
  // Access time of the fitted display memory, in nanoseconds.
  localparam int unsigned MEM_ACCESS_NS = 300;
  // Memory access time expressed in clock cycles, rounded up.
  localparam int unsigned MEM_ACCESS_CYC = (MEM_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  // Tap used for the fitted memory.
  localparam logic [1:0] TAP_DEFAULT = 2'h1;
  // Cycles between successive shift register outputs (one per wait state).
  localparam logic [3:0] STAGE_CYCLES = 4'h1;

  // Ownership states of the display memory bus, Gray coded along the hand-over.
  typedef enum logic [2:0] {
    OWN_VIDEO   = 3'b000,
    FLOAT_VADDR = 3'b001,
    DESEL_VDEC  = 3'b011,
    HOST_ON     = 3'b010,
    HOST_DONE   = 3'b110
  } owner_t;

  // Host bus request as seen by the arbiter.
  typedef struct packed {
    logic as_n;
    logic rw;
    logic [HOST_ADDR_W-1:0] addr;
    logic [HOST_DATA_W-1:0] wdata;
  } host_req_t;

  // Memory bus control outputs.
  typedef struct packed {
    logic vaddr_float;
    logic vdec_sel;
    logic host_buf_en;
    logic host_drive_mem;
  } mem_ctl_t;

  // Supported access time for a tap, in nanoseconds.
  function automatic int unsigned tap_access_ns(input logic [1:0] tap);
    unique case (tap)
      2'h0: tap_access_ns = ACCESS_NS_TAP0;
      2'h1: tap_access_ns = ACCESS_NS_TAP1;
      2'h2: tap_access_ns = ACCESS_NS_TAP2;
      2'h3: tap_access_ns = ACCESS_NS_TAP3;
    endcase
  endfunction

  // Supported data setup time for a tap, in nanoseconds.
  function automatic int unsigned tap_setup_ns(input logic [1:0] tap);
    unique case (tap)
      2'h0: tap_setup_ns = SETUP_NS_TAP0;
      2'h1: tap_setup_ns = SETUP_NS_TAP1;
      2'h2: tap_setup_ns = SETUP_NS_TAP2;
      2'h3: tap_setup_ns = SETUP_NS_TAP3;
    endcase
  endfunction

endpackage

/* File: verilog/wait_shifter.sv */
// Wait-state shift register whose selected tap yields the transfer acknowledge.
`timescale 1ns/1ps
module wait_shifter
  import arbiter_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [1:0] tap_sel,
  output logic ack
);

  // Chain length: the last tap lies two chain bits per step past the first.
  localparam int unsigned CHAIN_W = WAITS_PER_TAP * (TAP_COUNT - 2) + 1;

  // Chain register; bit k is set once start has been high for k+1 edges.
  logic [CHAIN_W-1:0] chain_q;
  logic [CHAIN_W-1:0] chain_d;
  // Shift input of each chain bit.
  logic [CHAIN_W-1:0] shift_in;
  // Tap outputs; bit n is wait_tap_n.
  logic [TAP_COUNT-1:0] tap_hit;

  // The first bit is fed by a constant one, later bits by their neighbour.
  genvar g;
  generate
    for (g = 0; g < CHAIN_W; g++)
    begin : g_shift
      if (g == 0)
      begin : g_first
        assign shift_in[g] = 1'b1;
      end
      else
      begin : g_rest
        assign shift_in[g] = chain_q[g-1];
      end
    end
  endgenerate

  // Tap zero fires at once; tap one is chain bit 0, one edge later, and each later tap lies two chain bits further on.
  // R12 two waits per tap from tap one on; tap one adds one over tap zero
  genvar t;
  generate
    for (t = 0; t < TAP_COUNT; t++)
    begin : g_tap
      if (t == 0)
      begin : g_zero
        assign tap_hit[t] = 1'b1;
      end
      else
      begin : g_later
        assign tap_hit[t] = chain_q[WAITS_PER_TAP*(t-1)];
      end
    end
  endgenerate

  // Next state: shift while an access runs, clear while idle.
  always_comb
  begin
    chain_d = shift_in;
    if (!start)
    begin
      // R17 clear when idle
      chain_d = '0;
    end
  end

  // Register the chain; the acknowledge is registered too, so tap zero still
  // costs one edge, which only matters for memory faster than the fitted part.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chain_q <= '0;
      ack <= 1'b0;
    end
    else
    begin
      chain_q <= chain_d;
      // R12 tap selects ack
      ack <= start & tap_hit[tap_sel];
    end
  end

endmodule

/* File: verilog/mode_latch.sv */
// Four-bit mode latch loaded from even-address host writes.
`timescale 1ns/1ps
module mode_latch
  import arbiter_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [MODE_W-1:0] din,
  output logic [MODE_W-1:0] mode
);

  logic [MODE_W-1:0] mode_d;

  // Hold unless a qualifying write arrives; the last such write wins.
  always_comb
  begin
    // R07 even writes load
    mode_d = load ? din : mode;
  end

  // R08 holds between writes
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode <= MODE_RESET;
    end
    else
    begin
      mode <= mode_d;
    end
  end

endmodule

/* File: test/display_arbiter_chk.sv */
// Port checker for the display memory arbiter.
`timescale 1ns/1ps
module display_arbiter_chk
  import arbiter_pkg::*;
#(
  parameter logic [1:0] WAIT_TAP = TAP_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire host_req_t host_req,
  input wire logic [MODE_PINS-MODE_W-1:0] static_mode_bits,
  input wire logic frame_sync_pin,
  input wire logic host_rdata_oe,
  input wire logic transfer_acknowledge_n,
  input wire logic mem_wdata_oe,
  input wire logic mem_we_n,
  input wire mem_ctl_t mem_ctl,
  input wire logic [MODE_PINS-1:0] video_display_generator_mode,
  input wire logic frame_inactive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A tap too short for the memory is raised to tap one.
  localparam int ACK_CYC = 1 + 2 * ((WAIT_TAP == 2'h0) ? 1 : WAIT_TAP);
  // Edges seen with the host buffers on; saturates so it cannot wrap.
  logic [4:0] buf_cnt_q;
  logic [4:0] buf_cnt_d;
  // Next count.
  always_comb
  begin
    buf_cnt_d = 5'h00;
    if (mem_ctl.host_buf_en)
    begin
      buf_cnt_d = (buf_cnt_q == 5'h1f) ? buf_cnt_q : buf_cnt_q + 5'h01;
    end
  end
  // Count register.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      buf_cnt_q <= 5'h00;
    end
    else
    begin
      buf_cnt_q <= buf_cnt_d;
    end
  end
  // Hand-over steps, one edge apart.
  sequence s_handover;
    mem_ctl.vdec_sel && !mem_ctl.host_buf_en ##1 !mem_ctl.vdec_sel && !mem_ctl.host_buf_en
      ##1 mem_ctl.host_buf_en;
  endsequence
  property p_order;
    $rose(mem_ctl.vaddr_float) |-> s_handover;
  endproperty
  a_order: assert property (p_order) else $error("hand-over order broken");
  property p_buf_guard;
    mem_ctl.host_buf_en |-> mem_ctl.vaddr_float && !mem_ctl.vdec_sel;
  endproperty
  a_buf_guard: assert property (p_buf_guard) else $error("buffers on too early");
  property p_isolate;
    !mem_ctl.host_buf_en |-> !host_rdata_oe && !mem_wdata_oe && mem_we_n
      && !mem_ctl.host_drive_mem;
  endproperty
  a_isolate: assert property (p_isolate) else $error("host not isolated");
  property p_release;
    host_req.as_n [*3] |-> mem_ctl.vdec_sel && !mem_ctl.vaddr_float && transfer_acknowledge_n;
  endproperty
  a_release: assert property (p_release) else $error("video not given back");
  property p_ack_tap;
    $fell(transfer_acknowledge_n) |-> buf_cnt_q == ACK_CYC;
  endproperty
  a_ack_tap: assert property (p_ack_tap) else $error("wait state count wrong");
  property p_ack_buf;
    !transfer_acknowledge_n |-> mem_ctl.host_buf_en;
  endproperty
  a_ack_buf: assert property (p_ack_buf) else $error("ack outside access");
  property p_ack_hold;
    $rose(transfer_acknowledge_n) |-> $past(host_req.as_n, 2);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_mode_load;
    $changed(video_display_generator_mode[MODE_W-1:0]) |-> !$past(mem_we_n);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode changed without write");
  property p_upper;
    !$past(sys_rst) |->
      video_display_generator_mode[MODE_PINS-1:MODE_W] == $past(static_mode_bits);
  endproperty
  a_upper: assert property (p_upper) else $error("upper mode pins wrong");
  property p_frame;
    !frame_sync_pin [*7] |-> frame_inactive;
  endproperty
  a_frame: assert property (p_frame) else $error("frame inactive missed");
endmodule
bind display_arbiter display_arbiter_chk #(.WAIT_TAP(WAIT_TAP)) display_arbiter_chk_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .host_req(host_req),
  .static_mode_bits(static_mode_bits), .frame_sync_pin(frame_sync_pin),
  .host_rdata_oe(host_rdata_oe), .transfer_acknowledge_n(transfer_acknowledge_n),
  .mem_wdata_oe(mem_wdata_oe), .mem_we_n(mem_we_n), .mem_ctl(mem_ctl),
  .video_display_generator_mode(video_display_generator_mode),
  .frame_inactive(frame_inactive)
);

/* File: test/video_side_model.sv */
// Display memory and scanning generator on the arbiter's far side.
`timescale 1ns/1ps
module video_side_model
  import arbiter_pkg::*;
#(
  parameter int unsigned FRAME_CYC = 100,
  parameter int unsigned ACTIVE_CYC = 60
)
(
  input wire logic core_clk,
  input wire mem_ctl_t mem_ctl,
  input wire logic [DISP_ADDR_W-1:0] mem_addr,
  input wire logic [DISP_DATA_W-1:0] mem_wdata,
  input wire logic mem_wdata_oe,
  input wire logic mem_we_n,
  output logic [DISP_DATA_W-1:0] mem_rdata,
  output logic frame_sync_pin
);
  // Only sixteen cells are modelled; the tests stay in that range.
  logic [DISP_DATA_W-1:0] cells [16];
  // Undriven read bus flips every cycle so stale data cannot pass.
  logic [DISP_DATA_W-1:0] idle_q = 12'h5a5;
  int unsigned line_q = 0;
  // Scan position, idle pattern and host writes.
  always_ff @(posedge core_clk)
  begin
    line_q <= (line_q + 1) % FRAME_CYC;
    idle_q <= ~idle_q;
    if (mem_ctl.host_drive_mem && mem_wdata_oe && !mem_we_n)
    begin
      cells[mem_addr[3:0]] <= mem_wdata;
    end
  end
  assign mem_rdata = (mem_ctl.host_buf_en && mem_we_n) ? cells[mem_addr[3:0]] : idle_q;
  assign frame_sync_pin = line_q < ACTIVE_CYC;
endmodule

/* File: test/shared_display_memory_arbiter_tb.sv */
// Self-checking testbench for the display memory arbiter.
`timescale 1ns/1ps
module shared_display_memory_arbiter_tb;
  import arbiter_pkg::*;
  logic core_clk;
  logic sys_rst;
  host_req_t host_req;
  logic [DISP_DATA_W-1:0] mem_rdata;
  logic [3:0] static_mode_bits;
  logic frame_sync_pin;
  logic [15:0] host_rdata;
  logic host_rdata_oe;
  logic transfer_acknowledge_n;
  logic [DISP_ADDR_W-1:0] mem_addr;
  logic [DISP_DATA_W-1:0] mem_wdata;
  logic mem_wdata_oe;
  logic mem_we_n;
  mem_ctl_t mem_ctl;
  logic [7:0] vmode;
  logic frame_inactive;
  logic [15:0] rd;
  int fails = 0;
  int n_compared = 0;
  display_arbiter display_arbiter_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .host_req(host_req), .mem_rdata(mem_rdata), .static_mode_bits(static_mode_bits),
    .frame_sync_pin(frame_sync_pin), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .transfer_acknowledge_n(transfer_acknowledge_n), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wdata_oe(mem_wdata_oe), .mem_we_n(mem_we_n),
    .mem_ctl(mem_ctl), .video_display_generator_mode(vmode), .frame_inactive(frame_inactive));
  video_side_model video_side_model_inst (.core_clk(core_clk), .mem_ctl(mem_ctl),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wdata_oe(mem_wdata_oe),
    .mem_we_n(mem_we_n), .mem_rdata(mem_rdata), .frame_sync_pin(frame_sync_pin));
  // Compare one value and count it.
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle bus state: video owns memory, host cut off, ack negated.
  task automatic cmp_idle();
    cmp_val("idle", 16'h0023, {mem_ctl, host_rdata_oe, transfer_acknowledge_n, mem_we_n});
  endtask
  // One host word access; waits for the acknowledge before release.
  task automatic host_access(input logic [12:0] off, input logic rw, input logic [15:0] wd);
    int n;
    n = 0;
    while (!rw && frame_inactive !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    if (!rw)
    begin
      cmp_val("frame wait", 16'h0001, {15'h0, frame_inactive});
    end
    @(posedge core_clk);
    host_req <= '{as_n: 1'b0, rw: rw, addr: DISP_BASE_DEFAULT + off, wdata: wd};
    n = 0;
    while (transfer_acknowledge_n !== 1'b0 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    cmp_val("ack", 16'h0000, {15'h0, transfer_acknowledge_n});
    rd = host_rdata;
    host_req.as_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_write_read();
    host_access(13'h0000, 1'b0, 16'ha5c3);
    host_access(13'h0000, 1'b1, 16'h0000);
    cmp_val("rdata", 16'h05c3, rd);
    cmp_val("mode", 16'h000a, {12'h0, vmode[3:0]});
  endtask
  task automatic t_odd();
    host_access(13'h0001, 1'b0, 16'h3fff);
    host_access(13'h0001, 1'b1, 16'h0000);
    cmp_val("rdata odd", 16'h0fff, rd);
    cmp_val("mode odd", 16'h000a, {12'h0, vmode[3:0]});
  endtask
  task automatic t_even_pair();
    host_access(13'h0002, 1'b0, 16'h7123);
    host_access(13'h0004, 1'b0, 16'hc456);
    host_access(13'h0004, 1'b1, 16'h0000);
    cmp_val("rdata pair", 16'h0456, rd);
    cmp_val("mode pair", 16'h000c, {12'h0, vmode[3:0]});
  endtask
  task automatic t_outside();
    @(posedge core_clk);
    host_req <= '{as_n: 1'b0, rw: 1'b1, addr: DISP_BASE_DEFAULT + DISP_WORDS, wdata: 16'h0};
    repeat (12) @(posedge core_clk);
    cmp_idle();
    host_req.as_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_static();
    static_mode_bits <= 4'h9;
    repeat (3) @(posedge core_clk);
    cmp_val("upper mode", 16'h009c, {8'h0, vmode});
  endtask
  task automatic t_reset_mid();
    @(posedge core_clk);
    host_req <= '{as_n: 1'b0, rw: 1'b0, addr: DISP_BASE_DEFAULT + 23'h6, wdata: 16'h5000};
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b1;
    host_req.as_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    cmp_idle();
    cmp_val("mode reset", 16'h0000, {12'h0, vmode[3:0]});
  endtask
  // Print the verdict and stop.
  task automatic results();
    if (fails == 0 && n_compared > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    sys_rst = 1'b1;
    host_req = '{as_n: 1'b1, rw: 1'b1, addr: 23'h0, wdata: 16'h0};
    static_mode_bits = 4'h3;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    cmp_idle();
    t_write_read();
    t_odd();
    t_even_pair();
    t_outside();
    t_static();
    t_reset_mid();
    results();
  end
  // About 155 cycles are needed, writes included that wait for the inactive frame period; 20,000 is ample.
  initial
  begin
    #400000;
    fails++;
    results();
  end
endmodule
